/* tpc_defines.vh */
// Constants for the timer channel pin control block.
// Included by tpc_timer.v; definitions only.
`ifndef TPC_DEFINES_VH
`define TPC_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TPC_OFS_CTRL 8'h00
`define TPC_OFS_COUNT 8'h04
`define TPC_OFS_MODULO 8'h08
`define TPC_OFS_CH_BASE 8'h10
`define TPC_CH_STRIDE_LOG2 3
`define TPC_OFS_CH_VALUE 3'h4
`define TPC_OFS_CH_CTRL 3'h0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TPC_CTRL_CLK_LSB 0
`define TPC_CTRL_CENTER 2
`define TPC_CTRL_PS_LSB 3
`define TPC_CTRL_OVF 7
`define TPC_CHC_ELS_LSB 0
`define TPC_CHC_MODE_LSB 2
`define TPC_CHC_FLAG 4

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define TPC_CLK_NONE 2'h0
`define TPC_CLK_BUS 2'h1
`define TPC_CLK_FIXED 2'h2
`define TPC_CLK_EXT 2'h3
`define TPC_ELS_OFF 2'h0
`define TPC_ELS_RISE 2'h1
`define TPC_ELS_FALL 2'h2
`define TPC_ELS_BOTH 2'h3
`define TPC_ELS_TOGGLE 2'h1
`define TPC_ELS_CLEAR 2'h2
`define TPC_ELS_SET 2'h3
`define TPC_MODE_CAPTURE 2'h0
`define TPC_MODE_COMPARE 2'h1
`define TPC_MODULO_RST 16'h0000
`define TPC_COUNT_MAX 16'hFFFF
`define TPC_COUNT_ZERO 16'h0000
`define TPC_CH_COUNT 2

`endif

/* tpc_timer.v */
// 16-bit timer with capture, compare, edge and center PWM channels.
// Assumes an AHB-Lite master on clk and async pins on extTimerClockIn and channelPinIn.
`timescale 1ns/1ps
`include "tpc_defines.vh"

module tpc_timer #(
    parameter CH_COUNT = `TPC_CH_COUNT
) (
    input wire clk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire fixedClockTick,
    input wire extTimerClockIn,
    input wire [CH_COUNT-1:0] channelPinIn,
    output wire [CH_COUNT-1:0] channelPinOut,
    output wire [CH_COUNT-1:0] channelPinOeN,
    output wire [CH_COUNT-1:0] channelPinOwned
);

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    reg wrPend_q;
    reg [7:0] wrAddr_q;
    wire addrPhase = hsel & htrans[1] & hready;
    wire wrNow = wrPend_q;
    wire [31:0] wdat = hwdata;
    wire wrCtrl = wrNow && (wrAddr_q == `TPC_OFS_CTRL);
    wire wrCount = wrNow && (wrAddr_q == `TPC_OFS_COUNT);
    wire wrMod = wrNow && (wrAddr_q == `TPC_OFS_MODULO);

    reg [1:0] clockSourceSelect_q;
    reg centerAlignSelect_q;
    reg [2:0] prescale_q;
    reg overflowFlag_q;
    reg [15:0] moduloValue_q;
    reg [15:0] timerCount_q;
    reg countDown_q;
    reg [6:0] prescaleCnt_q;
    wire [CH_COUNT*8-1:0] chCtrlAll;
    wire [CH_COUNT*16-1:0] chValAll;

    wire [7:0] rdOfs = haddr[7:0] - `TPC_OFS_CH_BASE;
    wire [7:0] rdIdx = rdOfs >> `TPC_CH_STRIDE_LOG2;
    reg [31:0] rdData;
    always @* begin
        rdData = 32'h0000_0000;
        if (haddr[7:0] == `TPC_OFS_CTRL) begin
            rdData[7:0] = {overflowFlag_q, 1'b0, prescale_q, centerAlignSelect_q,
                clockSourceSelect_q};
        end else if (haddr[7:0] == `TPC_OFS_COUNT) begin
            rdData[15:0] = timerCount_q;
        end else if (haddr[7:0] == `TPC_OFS_MODULO) begin
            rdData[15:0] = moduloValue_q;
        end else if (haddr[7:0] >= `TPC_OFS_CH_BASE && rdIdx < CH_COUNT) begin
            if (rdOfs[2:0] == `TPC_OFS_CH_VALUE) begin
                rdData[15:0] = chValAll[rdIdx*16 +: 16];
            end else if (rdOfs[2:0] == `TPC_OFS_CH_CTRL) begin
                rdData[7:0] = chCtrlAll[rdIdx*8 +: 8];
            end
        end
    end

    // Zero wait states: read data is fetched in the address phase
    always @(posedge clk) begin
        if (rst) begin
            wrPend_q <= 1'b0;
            wrAddr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wrPend_q <= addrPhase & hwrite;
            if (addrPhase) begin
                wrAddr_q <= haddr[7:0];
            end
            if (addrPhase && !hwrite) begin
                hrdata <= rdData;
            end
        end
    end

    // ----------------------------------------------------------------
    // External clock synchroniser
    // ----------------------------------------------------------------
    reg [2:0] extSync_q;
    reg extLvl_q;
    wire extAgree = extSync_q[1] == extSync_q[2];
    wire extRise = extAgree && extSync_q[2] && !extLvl_q;
    always @(posedge clk) begin
        if (rst) begin
            extSync_q <= 3'h0;
            extLvl_q <= 1'b0;
        end else begin
            extSync_q <= {extSync_q[1:0], extTimerClockIn};
            if (extAgree) begin
                extLvl_q <= extSync_q[2];
            end
        end
    end

    // ----------------------------------------------------------------
    // Clock select, prescaler and counter
    // ----------------------------------------------------------------
    reg srcEn;
    always @* begin
        case (clockSourceSelect_q)
            `TPC_CLK_BUS: srcEn = 1'b1;
            `TPC_CLK_FIXED: srcEn = fixedClockTick;
            `TPC_CLK_EXT: srcEn = extRise;
            default: srcEn = 1'b0;
        endcase
    end
    wire [6:0] psMask = 7'h7F >> (3'h7 - prescale_q);
    wire tick = srcEn && ((prescaleCnt_q & psMask) == psMask);
    wire [15:0] modEff = (moduloValue_q == `TPC_COUNT_ZERO) ? `TPC_COUNT_MAX : moduloValue_q;

    reg [15:0] countD;
    reg downD;
    reg wrapD;
    always @* begin
        countD = timerCount_q;
        downD = countDown_q;
        wrapD = 1'b0;
        if (tick) begin
            if (centerAlignSelect_q) begin
                if (!countDown_q && timerCount_q >= modEff) begin
                    downD = 1'b1;
                    countD = timerCount_q - 16'h0001;
                end else if (countDown_q && timerCount_q == `TPC_COUNT_ZERO) begin
                    downD = 1'b0;
                    wrapD = 1'b1;
                    countD = timerCount_q + 16'h0001;
                end else if (countDown_q) begin
                    countD = timerCount_q - 16'h0001;
                end else begin
                    countD = timerCount_q + 16'h0001;
                end
            end else begin
                downD = 1'b0;
                if (timerCount_q >= modEff) begin
                    countD = `TPC_COUNT_ZERO;
                    wrapD = 1'b1;
                end else begin
                    countD = timerCount_q + 16'h0001;
                end
            end
        end
    end
    // Any count write restarts the period; events of that cycle are dropped
    wire cntEvt = tick && !wrCount;

    always @(posedge clk) begin
        if (rst) begin
            clockSourceSelect_q <= `TPC_CLK_NONE;
            centerAlignSelect_q <= 1'b0;
            prescale_q <= 3'h0;
            overflowFlag_q <= 1'b0;
            moduloValue_q <= `TPC_MODULO_RST;
            timerCount_q <= `TPC_COUNT_ZERO;
            countDown_q <= 1'b0;
            prescaleCnt_q <= 7'h00;
        end else begin
            if (wrCtrl) begin
                clockSourceSelect_q <= wdat[`TPC_CTRL_CLK_LSB +: 2];
                centerAlignSelect_q <= wdat[`TPC_CTRL_CENTER];
                prescale_q <= wdat[`TPC_CTRL_PS_LSB +: 3];
            end
            if (wrMod) begin
                moduloValue_q <= wdat[15:0];
            end
            // Set beats write-one clear
            if (cntEvt && wrapD) begin
                overflowFlag_q <= 1'b1;
            end else if (wrCtrl && wdat[`TPC_CTRL_OVF]) begin
                overflowFlag_q <= 1'b0;
            end
            if (wrCount) begin
                timerCount_q <= `TPC_COUNT_ZERO;
                countDown_q <= 1'b0;
                prescaleCnt_q <= 7'h00;
            end else begin
                if (srcEn) begin
                    prescaleCnt_q <= prescaleCnt_q + 7'h01;
                end
                timerCount_q <= countD;
                countDown_q <= downD;
            end
        end
    end

    // ----------------------------------------------------------------
    // Channels
    // ----------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < CH_COUNT; i = i + 1) begin : gCh
            reg [1:0] edgeLevelSelect_q;
            reg [1:0] channelModeBits_q;
            reg flag_q;
            reg [15:0] value_q;
            reg [2:0] pinSync_q;
            reg pinLvl_q;
            reg pinOut_q;
            reg pinOeN_q;
            reg owned_q;
            wire chSel = wrAddr_q >= `TPC_OFS_CH_BASE &&
                ((wrAddr_q - `TPC_OFS_CH_BASE) >> `TPC_CH_STRIDE_LOG2) == i;
            wire wrChCtrl = wrNow && chSel && wrAddr_q[2:0] == `TPC_OFS_CH_CTRL;
            wire wrChVal = wrNow && chSel && wrAddr_q[2:0] == `TPC_OFS_CH_VALUE;
            wire elsOn = edgeLevelSelect_q != `TPC_ELS_OFF;
            wire own = elsOn && clockSourceSelect_q != `TPC_CLK_NONE;
            wire isCapture = !centerAlignSelect_q &&
                channelModeBits_q == `TPC_MODE_CAPTURE;
            wire isCompare = !centerAlignSelect_q && channelModeBits_q == `TPC_MODE_COMPARE;
            wire isEdgePwm = !centerAlignSelect_q && channelModeBits_q[1];
            wire drive = own && !isCapture;
            wire pinAgree = pinSync_q[1] == pinSync_q[2];
            wire rise = pinAgree && pinSync_q[2] && !pinLvl_q;
            wire fall = pinAgree && !pinSync_q[2] && pinLvl_q;
            // Both sync stages must agree, so pulses under about two clocks may be lost
            wire capEvt = own && isCapture && (
                (edgeLevelSelect_q[0] && rise) || (edgeLevelSelect_q[1] && fall));
            wire match = cntEvt && countD == value_q;
            wire periodStart = cntEvt && countD == `TPC_COUNT_ZERO && !centerAlignSelect_q;
            // Compare flag runs even with a released pin, as a software timer
            wire cmpFlag = match && !isCapture;
            reg outD;
            always @* begin
                outD = pinOut_q;
                if (centerAlignSelect_q) begin
                    if (match) begin
                        // Direction on arrival, so matches next to the turns act right
                        outD = downD ^ edgeLevelSelect_q[0];
                    end
                end else if (isEdgePwm) begin
                    if (periodStart) begin
                        outD = !edgeLevelSelect_q[0];
                    end
                    if (match) begin
                        outD = edgeLevelSelect_q[0];
                    end
                end else if (isCompare && match) begin
                    case (edgeLevelSelect_q)
                        `TPC_ELS_TOGGLE: outD = !pinOut_q;
                        `TPC_ELS_CLEAR: outD = 1'b0;
                        `TPC_ELS_SET: outD = 1'b1;
                        default: outD = pinOut_q;
                    endcase
                end
            end
            always @(posedge clk) begin
                if (rst) begin
                    edgeLevelSelect_q <= `TPC_ELS_OFF;
                    channelModeBits_q <= `TPC_MODE_CAPTURE;
                    flag_q <= 1'b0;
                    value_q <= `TPC_COUNT_ZERO;
                    pinSync_q <= 3'h0;
                    pinLvl_q <= 1'b0;
                    pinOut_q <= 1'b0;
                    pinOeN_q <= 1'b1;
                    owned_q <= 1'b0;
                end else begin
                    pinSync_q <= {pinSync_q[1:0], channelPinIn[i]};
                    if (pinAgree) begin
                        pinLvl_q <= pinSync_q[2];
                    end
                    if (wrChCtrl) begin
                        edgeLevelSelect_q <= wdat[`TPC_CHC_ELS_LSB +: 2];
                        channelModeBits_q <= wdat[`TPC_CHC_MODE_LSB +: 2];
                    end
                    if (capEvt) begin
                        value_q <= timerCount_q;
                    end else if (wrChVal) begin
                        value_q <= wdat[15:0];
                    end
                    if (capEvt || cmpFlag) begin
                        flag_q <= 1'b1;
                    end else if (wrChCtrl && wdat[`TPC_CHC_FLAG]) begin
                        flag_q <= 1'b0;
                    end
                    // Taking over the pin starts from the level it already shows
                    if (drive && pinOeN_q) begin
                        pinOut_q <= pinLvl_q;
                    end else begin
                        pinOut_q <= outD;
                    end
                    pinOeN_q <= !drive;
                    owned_q <= own;
                end
            end
            assign chCtrlAll[i*8 +: 8] = {3'h0, flag_q, channelModeBits_q, edgeLevelSelect_q};
            assign chValAll[i*16 +: 16] = value_q;
            assign channelPinOut[i] = pinOut_q;
            assign channelPinOeN[i] = pinOeN_q;
            assign channelPinOwned[i] = owned_q;
        end
    endgenerate

endmodule

/* tpc_timer_properties.sv */
// Pin ownership checker for tpc_timer, bound to its ports.
// Assumes zero-wait bus writes and the register map of the design.
`timescale 1ns/1ps
module tpc_timer_properties #(parameter CH_COUNT = 2) (
    input wire clk,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire fixedClockTick,
    input wire extTimerClockIn,
    input wire [CH_COUNT-1:0] channelPinIn,
    input wire [CH_COUNT-1:0] channelPinOut,
    input wire [CH_COUNT-1:0] channelPinOeN,
    input wire [CH_COUNT-1:0] channelPinOwned
);
    // Shadow of the configuration, rebuilt from bus writes
    reg shWr_q;
    reg [7:0] shAdr_q;
    reg [7:0] shCtl_q;
    reg [3:0] shCh_q [0:CH_COUNT-1];
    integer k;
    always @(posedge clk) begin
        shWr_q <= hsel && htrans[1] && hready && hwrite && !rst;
        shAdr_q <= haddr[7:0];
        if (rst)
            shCtl_q <= 8'h00;
        else if (shWr_q && shAdr_q == 8'h00)
            shCtl_q <= hwdata[7:0];
        for (k = 0; k < CH_COUNT; k = k + 1)
            if (rst)
                shCh_q[k] <= 4'h0;
            else if (shWr_q && {24'h0, shAdr_q} == 32'h10 + 8 * k)
                shCh_q[k] <= hwdata[3:0];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_reset; $fell(rst) |-> channelPinOwned == '0 && &channelPinOeN; endproperty
    a_reset: assert property (p_reset) else $error("pins held after reset");
    genvar g;
    for (g = 0; g < CH_COUNT; g = g + 1) begin : gCh
        // Outputs lag the register by one clock, so each mode must hold three samples
        wire on = shCtl_q[1:0] != 2'h0 && shCh_q[g][1:0] != 2'h0;
        wire dr = !channelPinOeN[g];
        property p_off; (!on) [*3] |-> !channelPinOwned[g] && !dr; endproperty
        a_off: assert property (p_off) else $error("pin not released");
        property p_swt;
            (shCtl_q[1:0] == 2'h3 && shCh_q[g] == 4'h4) [*3] |-> !channelPinOwned[g];
        endproperty
        a_swt: assert property (p_swt) else $error("soft timer took pin");
        property p_cen; (on && shCtl_q[2]) [*3] |-> dr && channelPinOwned[g]; endproperty
        a_cen: assert property (p_cen) else $error("center pin not driven");
        property p_cap;
            (on && !shCtl_q[2] && shCh_q[g][3:2] == 2'h0) [*3] |-> channelPinOwned[g] && !dr;
        endproperty
        a_cap: assert property (p_cap) else $error("capture pin not input");
        property p_cmp; (on && !shCtl_q[2] && shCh_q[g][3:2] == 2'h1) [*3] |-> dr; endproperty
        a_cmp: assert property (p_cmp) else $error("compare pin not driven");
        property p_pwm; (on && !shCtl_q[2] && shCh_q[g][3]) [*3] |-> dr; endproperty
        a_pwm: assert property (p_pwm) else $error("pwm pin not driven");
        property p_own; dr |-> channelPinOwned[g]; endproperty
        a_own: assert property (p_own) else $error("driven pin not owned");
    end
    cover property (shCtl_q[2] && !channelPinOeN[0]);
    cover property (channelPinOwned[0] && channelPinOeN[0]);
    cover property (shCtl_q[1:0] == 2'h3 && extTimerClockIn);
endmodule

bind tpc_timer tpc_timer_properties #(.CH_COUNT(CH_COUNT)) u_props (.clk(clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fixedClockTick(fixedClockTick), .extTimerClockIn(extTimerClockIn),
    .channelPinIn(channelPinIn), .channelPinOut(channelPinOut),
    .channelPinOeN(channelPinOeN), .channelPinOwned(channelPinOwned));

/* tpc_pin_model.sv */
// Far-side model: a signal source on each channel pin and an external clock source.
// Assumes the timer's active-low output enables; the pins have no pull device.
`timescale 1ns/1ps
module tpc_pin_model #(parameter CH_COUNT = 2) (
    input wire [CH_COUNT-1:0] channelPinOut,
    input wire [CH_COUNT-1:0] channelPinOeN,
    input wire [CH_COUNT-1:0] srcLevel,
    input wire extRun,
    input wire [7:0] extHalfNs,
    output wire [CH_COUNT-1:0] channelPinIn,
    output reg extTimerClockIn
);
    // A driven pin reads back the timer's level, a released one the source's
    assign channelPinIn = (~channelPinOeN & channelPinOut) | (channelPinOeN & srcLevel);
    initial begin
        extTimerClockIn = 1'b0;
        #3;
        // Half periods of 20 ns or more keep the source at or below a quarter of the bus rate
        forever begin
            #(extHalfNs);
            extTimerClockIn = extRun ? ~extTimerClockIn : 1'b0;
        end
    end
endmodule

/* tpc_timer_tb_top.sv */
// Self-checking bench for tpc_timer: ownership table, PWM, compare, capture, clocks.
// Assumes tpc_pin_model on the pins and the zero-wait bus of the design.
`timescale 1ns/1ps
module tpc_timer_tb_top;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg hsel = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [31:0] hwdata = 32'h0;
    reg tick_q = 1'b0;
    reg [2:0] div_q = 3'h0;
    reg [1:0] src = 2'h0;
    reg extRun = 1'b0;
    reg [7:0] extHalf = 8'h14;
    wire [31:0] hrdata;
    wire hreadyout;
    wire hresp;
    wire ext_timer_clock_in;
    wire [1:0] pinIn;
    wire [1:0] pinOut;
    wire [1:0] pinOeN;
    wire [1:0] pinOwned;
    reg [31:0] rd;
    reg [15:0] row [0:7];
    int lo[6] = '{0, 199, 38, 47, 27, 99};
    int hiLim[6] = '{0, 206, 42, 52, 30, 103};
    integer n_errors = 0;
    integer checked = 0;
    integer i;
    integer hi0;
    integer hi1;
    integer ed0;
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        div_q <= (div_q == 3'h4) ? 3'h0 : div_q + 3'h1;
        tick_q <= div_q == 3'h4;
    end
    tpc_timer #(.CH_COUNT(2)) i_dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fixedClockTick(tick_q),
        .extTimerClockIn(ext_timer_clock_in), .channelPinIn(pinIn), .channelPinOut(pinOut),
        .channelPinOeN(pinOeN), .channelPinOwned(pinOwned));
    tpc_pin_model #(.CH_COUNT(2)) i_pins (.channelPinOut(pinOut), .channelPinOeN(pinOeN),
        .srcLevel(src), .extRun(extRun), .extHalfNs(extHalf), .channelPinIn(pinIn),
        .extTimerClockIn(ext_timer_clock_in));
    task cmp(input [31:0] e, input [31:0] a);
        begin
            checked = checked + 1;
            if (a !== e) begin
                n_errors = n_errors + 1;
                $display("mismatch at %0t: expected %h got %h", $time, e, a);
            end
        end
    endtask
    task bus(input wr, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            hsel <= 1'b1;
            haddr <= {24'h0, a};
            htrans <= 2'h2;
            hwrite <= wr;
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge clk);
            while (hreadyout !== 1'b1) @(posedge clk);
            rd = hrdata;
        end
    endtask
    // Counts high samples of both pins and level changes of pin 0
    task measure(input integer cyc);
        reg p;
        begin
            hi0 = 0;
            hi1 = 0;
            ed0 = 0;
            @(negedge clk);
            p = pinOut[0];
            repeat (cyc) begin
                @(negedge clk);
                hi0 = hi0 + (pinOut[0] === 1'b1);
                hi1 = hi1 + (pinOut[1] === 1'b1);
                ed0 = ed0 + (pinOut[0] !== p);
                p = pinOut[0];
            end
        end
    endtask
    task test_done;
        begin
            $display("n_errors %0d checked %0d", n_errors, checked);
            if (n_errors == 0 && checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        #100000;
        n_errors = n_errors + 1;
        test_done;
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        // Row: control, channel control, expected {owned, output enable low-active}
        row[0] = {8'h01, 4'h4, 4'h1};
        row[1] = {8'h00, 4'h5, 4'h1};
        row[2] = {8'h01, 4'h1, 4'h3};
        row[3] = {8'h01, 4'h7, 4'h2};
        row[4] = {8'h01, 4'hA, 4'h2};
        row[5] = {8'h05, 4'h2, 4'h2};
        row[6] = {8'h03, 4'h4, 4'h1};
        row[7] = {8'h02, 4'h3, 4'h3};
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            bus(1, 8'h00, {24'h0, row[i][15:8]});
            bus(1, 8'h10, {28'h0, row[i][7:4]});
            repeat (4) @(negedge clk);
            cmp({30'h0, row[i][1:0]}, {30'h0, pinOwned[0], pinOeN[0]});
        end
        // Second reset from a live configuration must hand every pin back
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        cmp(32'h3, {28'h0, pinOwned, pinOeN});
        cmp(32'h2, {30'h0, hreadyout, hresp});
        bus(0, 8'h00, 0);
        cmp(0, rd);
        bus(1, 8'hFC, 32'hFFFFFFFF);
        bus(0, 8'hFC, 0);
        cmp(0, rd);
        bus(1, 8'h08, 32'h8);
        bus(1, 8'h14, 32'h5);
        bus(1, 8'h1C, 32'h5);
        bus(1, 8'h10, 32'hA);
        bus(1, 8'h18, 32'h9);
        bus(1, 8'h00, 32'h1);
        repeat (12) @(posedge clk);
        measure(27);
        cmp(15, hi0);
        cmp(12, hi1);
        cmp(6, ed0);
        // Center mode first, so the mode bits never pass through capture on a live pin
        bus(1, 8'h00, 32'h5);
        bus(1, 8'h10, 32'h2);
        bus(1, 8'h18, 32'h1);
        repeat (20) @(posedge clk);
        measure(32);
        cmp(20, hi0);
        cmp(12, hi1);
        bus(1, 8'h00, 0);
        src <= 2'h1;
        bus(1, 8'h14, 32'h3);
        bus(1, 8'h10, 32'h5);
        bus(1, 8'h04, 0);
        bus(1, 8'h00, 32'h1);
        repeat (2) @(negedge clk);
        cmp(1, pinOut[0]);
        measure(18);
        cmp(2, ed0);
        bus(0, 8'h10, 0);
        cmp(1, rd[4]);
        for (i = 6; i < 8; i = i + 1) begin
            bus(1, 8'h10, i + 16);
            repeat (12) @(negedge clk);
            cmp(i - 6, pinOut[0]);
        end
        // Rising only with a four-clock pulse, then both edges where the fall is kept
        bus(1, 8'h08, 0);
        src <= 2'h0;
        for (i = 0; i < 2; i = i + 1) begin
            bus(1, 8'h10, i ? 32'h13 : 32'h11);
            bus(1, 8'h04, 0);
            repeat (20) @(posedge clk);
            src <= 2'h1;
            repeat (4 + 2 * i) @(posedge clk);
            src <= 2'h0;
            repeat (10) @(posedge clk);
            bus(0, 8'h14, 0);
            cmp(1, rd >= 20 + 7 * i && rd <= 25 + 6 * i);
            bus(0, 8'h10, 0);
            cmp(1, rd[4]);
        end
        bus(1, 8'h10, 0);
        // Last case runs the bus clock through a divide-by-two prescaler
        for (i = 0; i < 6; i = i + 1) begin
            extRun <= i > 2;
            extHalf <= (i == 4) ? 8'h23 : 8'h14;
            bus(1, 8'h00, (i == 5) ? 32'h9 : (i > 3) ? 3 : i);
            bus(1, 8'h04, 0);
            repeat (200) @(posedge clk);
            bus(0, 8'h04, 0);
            cmp(1, rd >= lo[i] && rd <= hiLim[i]);
        end
        test_done;
    end
endmodule
